// ---- logic/rsri_cfg.svh ----
// Behaviour
// (RULE1) A new buck voltage code is reached by a ramp paced by a three-bit rate.
// (RULE2) While a buck ramps, forced PWM is on regardless of the mode bit.
// (RULE3) Ramping uses two phases if forced, else phases follow the rate.
// (RULE4) After the ramp, mode follows load, the force-PWM bit and the two-phase bit.
// (RULE5) A linear voltage change marks its power-good unreliable for under 100 us; the code marks it for BLANK_CYC cycles, a full 100 us.
// (RULE6) A buck follows the pin only when its on bit and follow bit are set.
// (RULE7) Pin-following bucks wait their four-bit up or down delay after pin edges.
// (RULE8) Linear regulators follow the pin the same way with their own delays.
// (RULE9) Auxiliary outputs rise and fall after their own delays from pin edges.
// (RULE10) Delays apply to pin edges only; on-bit changes act at once.
// (RULE11) Writing one to the soft reset trigger starts a reset; it self clears.
// (RULE12) Soft reset turns everything off, restores defaults and reloads OTP settings.
// (RULE13) The host interface state is untouched by a soft reset.
// (RULE14) Undervoltage turns everything off at once and restores defaults.
// (RULE15) Leaving undervoltage runs a power-on reset, OTP load, then start-up.
// (RULE16) Events set flags; the interrupt pin stays low while any flag pends; the code keeps it high for flags masked by i_ilim_mask or the OTP mask.
// (RULE17) After a fault or soft reset the reset flag is set on next start-up.
// (RULE18) The reset flag mask comes from OTP during reset; masked means no flag.
// (RULE19) Current limit keeps running, sets a maskable flag, shows live status.
// (RULE20) A buck below threshold for 1 ms is turned off with a short flag.
// (RULE21) A linear regulator below threshold for 1 ms is turned off likewise.
// (RULE22) Overheat turns everything off and sets a flag that holds while hot.
// (RULE23) Pin toggles during a delay restart it toward the latest pin level.
`ifndef RSRI_CFG_SVH
`define RSRI_CFG_SVH
`define RSRI_CLK_MHZ 125
`define RSRI_STEP_US 1000
`define RSRI_SHORT_US 1000
`define RSRI_BLANK_US 100
`define RSRI_STEP_CYC (`RSRI_STEP_US * `RSRI_CLK_MHZ)
`define RSRI_SHORT_CYC (`RSRI_SHORT_US * `RSRI_CLK_MHZ)
`define RSRI_BLANK_CYC (`RSRI_BLANK_US * `RSRI_CLK_MHZ)
`define RSRI_LOAD_CYC 16
`define RSRI_RAMP_BASE_CYC 12'h010
`define RSRI_DUAL_MIN_RATE 3'h4
`define RSRI_FLG_ILIM 0
`define RSRI_FLG_SHORT 4
`define RSRI_FLG_HEAT 8
`define RSRI_FLG_RST 9
`define RSRI_FLG_W 10
`define RSRI_IRQ_N_RST 1'b1
`define RSRI_PEND_RST 1'b1
`endif

// ---- logic/rsri_pkg.sv ----
package rsri_pkg;
  typedef enum logic [1:0] {
    RSRI_ST_OFF = 2'b00,
    RSRI_ST_LOAD = 2'b01,
    RSRI_ST_RUN = 2'b10
  } rsri_state_t;
  typedef struct packed {
    logic on_bit;
    logic pin_follow_select;
    logic [3:0] power_up_wait;
    logic [3:0] power_down_wait;
  } rsri_chan_cfg_t;
  typedef struct packed {
    rsri_chan_cfg_t seq;
    logic buck_force_pwm;
    logic [2:0] buck_ramp_rate_select;
    logic [7:0] buck_voltage_code;
  } rsri_buck_cfg_t;
  typedef struct packed {
    rsri_chan_cfg_t seq;
    logic [4:0] linreg_voltage_code;
  } rsri_lin_cfg_t;
endpackage

// ---- logic/rsri_top.sv ----
`timescale 1ns/10ps
`include "rsri_cfg.svh"
module rsri_top
#(
  parameter int STEP_CYC = `RSRI_STEP_CYC,
  parameter int SHORT_CYC = `RSRI_SHORT_CYC,
  parameter int BLANK_CYC = `RSRI_BLANK_CYC,
  parameter int LOAD_CYC = `RSRI_LOAD_CYC
)
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_en_pin,
  input wire rsri_pkg::rsri_buck_cfg_t [1:0] i_buck_cfg,
  input wire rsri_pkg::rsri_lin_cfg_t [1:0] i_lin_cfg,
  input wire rsri_pkg::rsri_chan_cfg_t [1:0] i_aux_cfg,
  input wire logic i_force_two_phase_pwm,
  input wire logic i_heavy_load,
  input wire logic i_soft_reset_trigger,
  input wire logic i_uvlo,
  input wire logic i_otp_reset_reg_mask,
  input wire logic i_overheat,
  input wire logic [3:0] i_ilim,
  input wire logic [3:0] i_ilim_mask,
  input wire logic [3:0] i_below_short,
  input wire logic [`RSRI_FLG_W-1:0] i_flag_clear,
  output logic [1:0] o_buck_on,
  output logic [1:0] o_linreg_on,
  output logic o_aux_output_one,
  output logic o_aux_output_two,
  output logic [1:0][7:0] o_buck_dac_code,
  output logic [1:0] o_buck_pwm_forced,
  output logic o_two_phase,
  output logic [1:0] o_lin_pg_unsure,
  output logic [`RSRI_FLG_W-1:0] o_flags,
  output logic [3:0] o_ilim_stat,
  output logic o_ready,
  output logic o_irq_out_n
);
  import rsri_pkg::*;

  localparam int TW = $clog2(STEP_CYC + 1);
  localparam int SW = $clog2(SHORT_CYC + 1);
  localparam int BW = $clog2(BLANK_CYC + 1);
  localparam int LW = $clog2(LOAD_CYC + 1);

  rsri_state_t state_q;
  logic [LW-1:0] load_cnt_q;
  logic pend_q;
  logic ready_q;
  logic otp_mask_q;
  logic srst_q;
  logic en_q;
  logic en_prev_q;
  logic tick_q;
  logic [TW-1:0] tick_cnt_q;
  logic [`RSRI_FLG_W-1:0] flags_q;
  logic [`RSRI_FLG_W-1:0] irq_mask;
  logic irq_n_q;
  logic [3:0] ilim_stat_q;
  logic [3:0] short_set;
  logic [5:0] chan_on;
  logic [5:0] chan_stop;
  logic [1:0] ramp_q;
  logic [1:0] pwm_q;
  logic two_q;
  logic rst_set;
  logic load_done;
  logic halt;
  logic rise;
  logic fall;
  rsri_chan_cfg_t [5:0] cc;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  assign cc = {i_aux_cfg, i_lin_cfg[1].seq, i_lin_cfg[0].seq,
               i_buck_cfg[1].seq, i_buck_cfg[0].seq};
  assign halt = (state_q != RSRI_ST_RUN) | srst_q | i_uvlo | i_overheat;
  assign rise = en_q & ~en_prev_q;
  assign fall = ~en_q & en_prev_q;
  assign load_done = (state_q == RSRI_ST_LOAD) && (load_cnt_q == LW'(LOAD_CYC - 1));
  assign rst_set = load_done & pend_q & ~otp_mask_q;
  assign chan_stop = {2'b00, flags_q[`RSRI_FLG_SHORT+3:`RSRI_FLG_SHORT]};
  assign irq_mask = {otp_mask_q, 5'h00, i_ilim_mask};

  // ---------------------------------------------
  // Reset sequencing
  // ---------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      srst_q <= 1'b0;
    else
      srst_q <= i_soft_reset_trigger; // [RULE11] [RULE13]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= RSRI_ST_OFF;
      load_cnt_q <= '0;
      pend_q <= `RSRI_PEND_RST;
      otp_mask_q <= 1'b0;
      ready_q <= 1'b0;
    end
    else if (i_uvlo || i_overheat)
    begin
      state_q <= RSRI_ST_OFF; // [RULE14] [RULE22]
      ready_q <= 1'b0;
      load_cnt_q <= '0;
      pend_q <= 1'b1; // [RULE17]
    end
    else if (srst_q)
    begin
      state_q <= RSRI_ST_LOAD; // [RULE12]
      ready_q <= 1'b0;
      load_cnt_q <= '0;
      pend_q <= 1'b1; // [RULE17]
    end
    else
    begin
      case (state_q)
        RSRI_ST_OFF:
        begin
          state_q <= RSRI_ST_LOAD; // [RULE15]
          load_cnt_q <= '0;
        end
        RSRI_ST_LOAD:
        begin
          otp_mask_q <= i_otp_reset_reg_mask; // [RULE18]
          load_cnt_q <= load_cnt_q + LW'(1);
          if (load_done)
          begin
            state_q <= RSRI_ST_RUN;
            pend_q <= 1'b0;
            ready_q <= 1'b1;
          end
        end
        RSRI_ST_RUN:
          state_q <= RSRI_ST_RUN;
        default:
        begin
          state_q <= RSRI_ST_OFF;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  assign o_ready = ready_q;

  soft_reset_off_a: assert property (srst_q |=> (chan_on == 6'h00)) // [RULE12]
    else $error("outputs not off after soft reset");
  uvlo_off_a: assert property (i_uvlo |=> (chan_on == 6'h00) && (flags_q == '0)) // [RULE14]
    else $error("undervoltage did not clear outputs and flags");

  // ---------------------------------------------
  // Pin sampling and delay step tick
  // ---------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      en_q <= 1'b0;
      en_prev_q <= 1'b0;
    end
    else
    begin
      en_q <= i_en_pin;
      en_prev_q <= halt ? 1'b0 : en_q; // [RULE15]
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || tick_cnt_q == TW'(STEP_CYC - 1))
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + TW'(1);
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      tick_q <= 1'b0;
    else
      tick_q <= (tick_cnt_q == TW'(STEP_CYC - 1));
  end

  // ---------------------------------------------
  // Per-output enable sequencing
  // ---------------------------------------------
  for (genvar g = 0; g < 6; g++)
  begin : g_ch
    logic on_q;
    logic pnd_q;
    logic [3:0] cnt_q;
    logic [3:0] wait_v;

    assign wait_v = rise ? cc[g].power_up_wait : cc[g].power_down_wait;
    assign chan_on[g] = on_q;

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rst_n || halt || chan_stop[g])
      begin
        on_q <= 1'b0;
        pnd_q <= 1'b0;
        cnt_q <= 4'h0;
      end
      else if (!cc[g].on_bit)
      begin
        on_q <= 1'b0; // [RULE6] [RULE10]
        pnd_q <= 1'b0;
      end
      else if (!cc[g].pin_follow_select)
      begin
        on_q <= 1'b1; // [RULE10]
        pnd_q <= 1'b0;
      end
      else if (rise || fall)
      begin
        if (wait_v == 4'h0)
        begin
          on_q <= en_q;
          pnd_q <= 1'b0;
        end
        else
        begin
          cnt_q <= wait_v; // [RULE7] [RULE8] [RULE9] [RULE23]
          pnd_q <= 1'b1;
        end
      end
      else if (pnd_q && tick_q)
      begin
        cnt_q <= cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          on_q <= en_q; // [RULE7] [RULE8] [RULE9]
          pnd_q <= 1'b0;
        end
      end
    end

    sequence s_edge_now;
      !halt && !chan_stop[g] && cc[g].on_bit && cc[g].pin_follow_select && (rise || fall);
    endsequence
    sequence s_wait_zero;
      wait_v == 4'h0;
    endsequence

    pin_nodelay_a: assert property ((s_edge_now and s_wait_zero) |=> on_q == $past(en_q)) // [RULE7]
      else $error("zero delay edge not followed");
    reg_direct_a: assert property (!halt && !chan_stop[g] && cc[g].on_bit && // [RULE10]
                                   !cc[g].pin_follow_select |=> on_q)
      else $error("register enable was delayed");

    if (g < 4)
    begin : g_sc
      logic [SW-1:0] sc_q;
      always_ff @(posedge i_ref_clk)
      begin
        if (!i_rst_n || !on_q || !i_below_short[g])
          sc_q <= '0;
        else if (sc_q != SW'(SHORT_CYC - 1))
          sc_q <= sc_q + SW'(1);
      end
      assign short_set[g] = on_q & i_below_short[g] & (sc_q == SW'(SHORT_CYC - 1)); // [RULE20] [RULE21]
      short_off_a: assert property (short_set[g] |=> ##1 !on_q) // [RULE20]
        else $error("shorted output not turned off");
    end
  end

  assign o_buck_on = chan_on[1:0];
  assign o_linreg_on = chan_on[3:2];
  assign o_aux_output_one = chan_on[4];
  assign o_aux_output_two = chan_on[5];

  // ---------------------------------------------
  // Buck voltage ramp and mode
  // ---------------------------------------------
  for (genvar b = 0; b < 2; b++)
  begin : g_ramp
    logic [7:0] dac_q;
    logic [11:0] rcnt_q;
    logic [7:0] tgt;

    assign tgt = i_buck_cfg[b].buck_voltage_code;
    assign o_buck_dac_code[b] = dac_q;

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rst_n || !chan_on[b])
      begin
        dac_q <= tgt;
        rcnt_q <= 12'h000;
        ramp_q[b] <= 1'b0;
      end
      else if (dac_q == tgt)
        ramp_q[b] <= 1'b0; // [RULE4]
      else
      begin
        ramp_q[b] <= 1'b1;
        if (rcnt_q != 12'h000)
          rcnt_q <= rcnt_q - 12'h001;
        else
        begin
          rcnt_q <= `RSRI_RAMP_BASE_CYC << (3'h7 - i_buck_cfg[b].buck_ramp_rate_select); // [RULE1]
          dac_q <= (dac_q < tgt) ? dac_q + 8'h01 : dac_q - 8'h01; // [RULE1]
        end
      end
    end

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rst_n)
        pwm_q[b] <= 1'b0;
      else
        pwm_q[b] <= ramp_q[b] | i_buck_cfg[b].buck_force_pwm; // [RULE2] [RULE4]
    end

    pwm_during_ramp_a: assert property (ramp_q[b] |=> pwm_q[b]) // [RULE2]
      else $error("ramp without forced PWM");
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      two_q <= 1'b0;
    else if (ramp_q[0])
      two_q <= i_force_two_phase_pwm | // [RULE3]
               (i_buck_cfg[0].buck_ramp_rate_select >= `RSRI_DUAL_MIN_RATE);
    else
      two_q <= i_force_two_phase_pwm | i_heavy_load; // [RULE4]
  end

  assign o_buck_pwm_forced = pwm_q;
  assign o_two_phase = two_q;

  forced_two_a: assert property (ramp_q[0] && i_force_two_phase_pwm |=> two_q) // [RULE3]
    else $error("forced two phase not used in ramp");

  // ---------------------------------------------
  // Linear power-good blanking
  // ---------------------------------------------
  for (genvar l = 0; l < 2; l++)
  begin : g_blank
    logic [4:0] code_q;
    logic [BW-1:0] bc_q;
    logic uns_q;

    always_ff @(posedge i_ref_clk)
    begin
      if (!i_rst_n)
      begin
        code_q <= 5'h00;
        bc_q <= '0;
        uns_q <= 1'b0;
      end
      else
      begin
        code_q <= i_lin_cfg[l].linreg_voltage_code;
        if (chan_on[2+l] && code_q != i_lin_cfg[l].linreg_voltage_code)
        begin
          bc_q <= BW'(BLANK_CYC); // [RULE5]
          uns_q <= 1'b1;
        end
        else if (bc_q != '0)
        begin
          bc_q <= bc_q - BW'(1);
          uns_q <= (bc_q != BW'(1));
        end
        else
          uns_q <= 1'b0;
      end
    end
    assign o_lin_pg_unsure[l] = uns_q;
  end

  // ---------------------------------------------
  // Flags and interrupt pin
  // ---------------------------------------------
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n || i_uvlo || srst_q)
      flags_q <= '0; // [RULE12] [RULE14]
    else
      flags_q <= (flags_q & ~i_flag_clear) | // [RULE19] [RULE22]
                 {rst_set, i_overheat, short_set, i_ilim}; // [RULE16] [RULE17]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      ilim_stat_q <= 4'h0;
    else
      ilim_stat_q <= i_ilim; // [RULE19]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      irq_n_q <= `RSRI_IRQ_N_RST;
    else
      irq_n_q <= ~|(flags_q & ~irq_mask); // [RULE16] [RULE18]
  end

  assign o_flags = flags_q;
  assign o_ilim_stat = ilim_stat_q;
  assign o_irq_out_n = irq_n_q;

  irq_pin_a: assert property (|(flags_q & ~irq_mask) |=> !o_irq_out_n) // [RULE16]
    else $error("interrupt pin not low with pending flag");
  ilim_hold_a: assert property (|i_ilim && !i_uvlo && !srst_q |=> // [RULE19]
                                ((flags_q[3:0] & $past(i_ilim)) == $past(i_ilim)) &&
                                (o_ilim_stat == $past(i_ilim)))
    else $error("current limit flag cleared while active");
  heat_off_a: assert property (i_overheat && !i_uvlo && !srst_q |=> // [RULE22]
                               chan_on == 6'h00 && flags_q[`RSRI_FLG_HEAT])
    else $error("overheat did not shut down");
  startup_flag_a: assert property (rst_set && !i_uvlo && !srst_q |=> flags_q[`RSRI_FLG_RST]) // [RULE17]
    else $error("reset flag not set on start-up");
  otp_mask_a: assert property (load_done && otp_mask_q |=> !$rose(flags_q[`RSRI_FLG_RST])) // [RULE18]
    else $error("masked reset flag raised");

endmodule

// ---- test/rsri_host_model.sv ----
`timescale 1ns/10ps
`include "rsri_cfg.svh"
module rsri_host_model
(
  input wire logic i_ref_clk,
  input wire logic i_pin_cmd,
  input wire logic i_srst_cmd,
  input wire logic [`RSRI_FLG_W-1:0] i_clr_cmd,
  output logic o_en_pin,
  output logic o_soft_reset_trigger,
  output logic [`RSRI_FLG_W-1:0] o_flag_clear
);
  // ----------------------------------------
  // Host side: pin level and one-cycle writes
  // ----------------------------------------
  // Power-good is not consulted by this host at all
  always_ff @(posedge i_ref_clk)
  begin
    o_en_pin <= i_pin_cmd;
    o_soft_reset_trigger <= i_srst_cmd;
    o_flag_clear <= i_clr_cmd;
  end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/10ps
`include "rsri_cfg.svh"
module tb;
  import rsri_pkg::*;
  localparam int STEP = 20;
  localparam int SHORTC = 30;
  localparam int BLANK = 10;
  localparam int LOADC = 16;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pin_cmd = 1'b0;
  logic srst_cmd = 1'b0;
  logic [`RSRI_FLG_W-1:0] clr_cmd = '0;
  logic en_pin, srst;
  logic [`RSRI_FLG_W-1:0] clr;
  rsri_buck_cfg_t [1:0] bcfg = '0;
  rsri_lin_cfg_t [1:0] lcfg = '0;
  rsri_chan_cfg_t [1:0] acfg = '0;
  logic f2p = 1'b0;
  logic heavy = 1'b0;
  logic uvlo = 1'b0;
  logic otpm = 1'b0;
  logic hot = 1'b0;
  logic [3:0] ilim = '0;
  logic [3:0] imask = '0;
  logic [3:0] below = '0;
  logic [1:0] b_on, l_on, pwm, unsure;
  logic a1, a2, two, ready, irq_n;
  logic [1:0][7:0] dac;
  logic [`RSRI_FLG_W-1:0] flags;
  logic [3:0] istat;
  wire [7:0] pv = {ready, irq_n, a2, a1, l_on, b_on};
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [7:0] lf = 8'h07;
  always #4 clk = ~clk;
  rsri_host_model i_host
  (
    .i_ref_clk(clk),
    .i_pin_cmd(pin_cmd),
    .i_srst_cmd(srst_cmd),
    .i_clr_cmd(clr_cmd),
    .o_en_pin(en_pin),
    .o_soft_reset_trigger(srst),
    .o_flag_clear(clr)
  );
  rsri_top #(.STEP_CYC(STEP), .SHORT_CYC(SHORTC), .BLANK_CYC(BLANK), .LOAD_CYC(LOADC)) i_dut
  (
    .i_ref_clk(clk),
    .i_rst_n(rst_n),
    .i_en_pin(en_pin),
    .i_buck_cfg(bcfg),
    .i_lin_cfg(lcfg),
    .i_aux_cfg(acfg),
    .i_force_two_phase_pwm(f2p),
    .i_heavy_load(heavy),
    .i_soft_reset_trigger(srst),
    .i_uvlo(uvlo),
    .i_otp_reset_reg_mask(otpm),
    .i_overheat(hot),
    .i_ilim(ilim),
    .i_ilim_mask(imask),
    .i_below_short(below),
    .i_flag_clear(clr),
    .o_buck_on(b_on),
    .o_linreg_on(l_on),
    .o_aux_output_one(a1),
    .o_aux_output_two(a2),
    .o_buck_dac_code(dac),
    .o_buck_pwm_forced(pwm),
    .o_two_phase(two),
    .o_lin_pg_unsure(unsure),
    .o_flags(flags),
    .o_ilim_stat(istat),
    .o_ready(ready),
    .o_irq_out_n(irq_n)
  );
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic int ramp_cyc(input int rate);
    return (16 << (7 - rate)) + 1;
  endfunction
  function automatic int dly_lo(input int k);
    return (k > 0) ? (k - 1) * STEP : 0;
  endfunction
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task automatic chk_rng(input int n, input int lo, input int hi, input string m);
    n_tests++;
    if (n < lo || n > hi)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s took %0d cycles", $time, m, n);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic wt(input int i, input logic v, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pv[i] !== v && n < lim);
  endtask
  task automatic set_seq(input int ch, input rsri_chan_cfg_t c);
    @(posedge clk);
    if (ch < 2)
      bcfg[ch].seq <= c;
    else if (ch < 4)
      lcfg[ch-2].seq <= c;
    else
      acfg[ch-4] <= c;
  endtask
  task automatic pulse(input int b);
    @(posedge clk);
    if (b < 0)
      srst_cmd <= 1'b1;
    else
      clr_cmd[b] <= 1'b1;
    @(posedge clk);
    srst_cmd <= 1'b0;
    clr_cmd <= '0;
  endtask
  task automatic drive_pin(input logic v);
    @(posedge clk);
    pin_cmd <= v;
  endtask
  task automatic end_test(input string s);
    $display("test %s done at %0t", s, $time);
  endtask
  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      conclude();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    int n;
    int k;
    int d;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wt(7, 1'b1, LOADC + 8, n);
    chk_rng(n, LOADC + 1, LOADC + 5, "ready");
    chk(flags[9], 1'b1, "reset flag");
    cy(1);
    chk(irq_n, 1'b0, "irq low");
    pulse(9);
    cy(4);
    chk(irq_n, 1'b1, "irq released");
    end_test("startup");
    for (int ch = 0; ch < 6; ch++)
    begin
      set_seq(ch, '{1'b1, 1'b0, 4'hF, 4'hF});
      wt(ch, 1'b1, 3, n);
      chk(pv[ch], 1'b1, "direct on");
      set_seq(ch, '{1'b0, 1'b1, 4'h0, 4'h0});
      wt(ch, 1'b0, 3, n);
      chk(pv[ch], 1'b0, "direct off");
    end
    end_test("direct");
    for (int ch = 0; ch < 6; ch++)
    begin
      lf = lfsr(lf);
      k = 1 + lf % 3;
      d = lf[7:6];
      set_seq(ch, '{1'b1, 1'b1, k[3:0], d[3:0]});
      cy(2 * STEP);
      drive_pin(1'b1);
      wt(ch, 1'b1, 4 * STEP, n);
      chk_rng(n, dly_lo(k), k * STEP + 4, "rise wait");
      drive_pin(1'b0);
      wt(ch, 1'b0, 4 * STEP, n);
      chk_rng(n, dly_lo(d), d * STEP + 4, "fall wait");
    end
    set_seq(0, '{1'b1, 1'b1, 4'h3, 4'h0});
    cy(2 * STEP);
    drive_pin(1'b1);
    cy(10);
    drive_pin(1'b0);
    wt(0, 1'b1, 4 * STEP, n);
    chk(pv[0], 1'b0, "cancelled rise");
    for (int ch = 0; ch < 6; ch++)
      set_seq(ch, '{1'b0, 1'b0, 4'h0, 4'h0});
    end_test("sequence");
    set_seq(0, '{1'b1, 1'b0, 4'h0, 4'h0});
    set_seq(2, '{1'b1, 1'b0, 4'h0, 4'h0});
    cy(4);
    @(posedge clk);
    f2p <= 1'b1;
    bcfg[0].buck_ramp_rate_select <= 3'h7;
    bcfg[0].buck_voltage_code <= bcfg[0].buck_voltage_code + 8'h03;
    lcfg[0].linreg_voltage_code <= 5'h0A;
    cy(3);
    chk(pwm[0], 1'b1, "pwm during ramp");
    chk(two, 1'b1, "two phase forced");
    chk(unsure[0], 1'b1, "pg unsure");
    cy(BLANK + 3);
    chk(unsure[0], 1'b0, "pg trusted");
    n = 0;
    while (dac[0] !== bcfg[0].buck_voltage_code && n < 4 * ramp_cyc(7))
    begin
      @(negedge clk);
      n++;
    end
    chk_rng(n, 2 * ramp_cyc(7) - 20, 3 * ramp_cyc(7) + 4, "ramp");
    cy(3);
    chk(pwm[0], 1'b0, "pwm after ramp");
    chk(two, 1'b1, "two phase bit");
    @(posedge clk);
    f2p <= 1'b0;
    bcfg[0].buck_force_pwm <= 1'b1;
    cy(3);
    chk(two, heavy, "phase by load");
    chk(pwm[0], 1'b1, "pwm bit");
    @(posedge clk);
    heavy <= 1'b1;
    cy(3);
    chk(two, 1'b1, "phase by heavy load");
    @(posedge clk);
    heavy <= 1'b0;
    bcfg[0].buck_ramp_rate_select <= 3'h5;
    bcfg[0].buck_voltage_code <= bcfg[0].buck_voltage_code + 8'h01;
    cy(3);
    chk(two, 1'b1, "auto phase add");
    cy(ramp_cyc(5) + 4);
    chk(two, 1'b0, "auto phase shed");
    end_test("ramp");
    @(posedge clk);
    ilim <= 4'h4;
    imask <= 4'h8;
    cy(3);
    chk(flags[2], 1'b1, "ilim flag");
    chk(istat[2], 1'b1, "ilim stat");
    chk(l_on[0], 1'b1, "keeps running");
    chk(irq_n, 1'b0, "ilim irq");
    pulse(2);
    cy(3);
    chk(flags[2], 1'b1, "no clear while limit");
    @(posedge clk);
    ilim <= 4'h8;
    pulse(2);
    cy(4);
    chk(flags[3:2], 2'b10, "masked flag only");
    chk(irq_n, 1'b1, "masked irq");
    @(posedge clk);
    ilim <= 4'h0;
    pulse(3);
    end_test("ilim");
    for (int ch = 0; ch < 4; ch++)
    begin
      set_seq(ch, '{1'b1, 1'b0, 4'h0, 4'h0});
      cy(2);
      @(posedge clk);
      below[ch] <= 1'b1;
      cy(SHORTC + 4);
      chk(pv[ch], 1'b0, "short off");
      chk(flags[4+ch], 1'b1, "short flag");
      chk(irq_n, 1'b0, "short irq");
      @(posedge clk);
      below <= 4'h0;
      pulse(4 + ch);
      cy(4);
      chk(flags[4+ch], 1'b0, "short cleared");
    end
    end_test("short");
    for (int ch = 0; ch < 6; ch++)
      set_seq(ch, '{1'b1, 1'b0, 4'h0, 4'h0});
    cy(3);
    @(posedge clk);
    hot <= 1'b1;
    cy(3);
    chk(pv[5:0], 6'h00, "heat off");
    chk(flags[8], 1'b1, "heat flag");
    pulse(8);
    cy(3);
    chk(flags[8], 1'b1, "heat held");
    @(posedge clk);
    hot <= 1'b0;
    wt(7, 1'b1, LOADC + 8, n);
    pulse(8);
    pulse(9);
    cy(4);
    chk(flags[9:8], 2'b00, "heat cleared");
    end_test("heat");
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      otpm <= m[0];
      pulse(-1);
      cy(3);
      chk(pv[5:0], 6'h00, "soft reset off");
      chk(ready, 1'b0, "reloading");
      wt(7, 1'b1, LOADC + 8, n);
      chk(flags[9], !m[0], "reset flag mask");
      pulse(9);
      cy(4);
      chk(irq_n, 1'b1, "host clear works");
    end
    end_test("soft reset");
    @(posedge clk);
    otpm <= 1'b0;
    uvlo <= 1'b1;
    cy(3);
    chk(pv[5:0], 6'h00, "uvlo off");
    chk(flags, '0, "uvlo defaults");
    @(posedge clk);
    uvlo <= 1'b0;
    wt(7, 1'b1, LOADC + 8, n);
    chk(flags[9], 1'b1, "por flag");
    cy(2);
    chk(b_on[0], 1'b1, "start per settings");
    end_test("uvlo");
    conclude();
  end
endmodule
